// [include/pfm_pkg.sv]
package pfm_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int VAL_W = 24;
    localparam int NUM_INST = 2;

    // Register offsets of filter instance 0; instance 1 sits one stride higher.
    localparam logic [11:0] INST_STRIDE = 12'h080;
    localparam logic [11:0] OFF_INSERTED = 12'h118;
    localparam logic [11:0] OFF_REGULAR = 12'h11c;
    localparam logic [11:0] OFF_HIGH_LIMIT = 12'h120;
    localparam logic [11:0] OFF_LOW_LIMIT = 12'h124;
    localparam logic [11:0] OFF_LIMIT_FLAGS = 12'h128;
    localparam logic [11:0] OFF_FLAG_CLEAR = 12'h12c;
    localparam logic [11:0] OFF_PEAK_HIGH = 12'h130;
    localparam logic [11:0] OFF_PEAK_LOW = 12'h134;
    localparam logic [11:0] OFF_CONTROL = 12'h138;

    // Field positions.
    localparam int VAL_LSB = 8;
    localparam int TAG_BIT = 0;
    localparam int DELAY_BIT = 4;
    localparam int ROUTE_LSB = 0;
    localparam int UPPER_FLAG_LSB = 8;
    localparam int LOWER_FLAG_LSB = 0;
    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_FAST_BIT = 1;
    localparam int HALF_LSB = 16;
    localparam int FAST_LSB = 8;

    // Reset values.
    localparam logic [31:0] PEAK_HIGH_RST = 32'h80000000;
    localparam logic [31:0] PEAK_LOW_RST = 32'h7fffff00;

    typedef struct packed {
        logic [VAL_W-1:0] inserted_result;
        logic inserted_source_tag;
        logic [VAL_W-1:0] regular_result;
        logic regular_source_tag;
        logic regular_delayed_tag;
        logic regular_done_flag;
        logic [VAL_W-1:0] upper_limit_value;
        logic [1:0] upper_break_route;
        logic [VAL_W-1:0] lower_limit_value;
        logic [1:0] lower_break_route;
        logic [1:0] upper_limit_flags;
        logic [1:0] lower_limit_flags;
        logic [VAL_W-1:0] peak_high_value;
        logic peak_high_source;
        logic [VAL_W-1:0] peak_low_value;
        logic peak_low_source;
        logic filter_on;
        logic fast_monitor_select;
    } pfm_inst_t;

    typedef struct packed {
        pfm_inst_t [NUM_INST-1:0] inst;
        logic [DATA_W-1:0] prdata;
        logic pslverr;
        logic [1:0] brk;
    } pfm_state_t;

endpackage

// [rtl/pfm_result_monitor.sv]
`timescale 1ns/1ps
module pfm_result_monitor
    import pfm_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [pfm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [pfm_pkg::DATA_W-1:0] pwdata_i,
    output logic [pfm_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic [pfm_pkg::NUM_INST-1:0] reg_done_i,
    input wire logic [pfm_pkg::NUM_INST-1:0][pfm_pkg::VAL_W-1:0] reg_data_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] reg_chan_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] reg_delayed_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] ins_done_i,
    input wire logic [pfm_pkg::NUM_INST-1:0][pfm_pkg::VAL_W-1:0] ins_data_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] ins_chan_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] mon_valid_i,
    input wire logic [pfm_pkg::NUM_INST-1:0][pfm_pkg::VAL_W-1:0] mon_data_i,
    input wire logic [pfm_pkg::NUM_INST-1:0] mon_chan_i,
    output logic [pfm_pkg::NUM_INST-1:0] regular_done_flag_o,
    output logic [pfm_pkg::NUM_INST-1:0] limit_event_flag_o,
    output logic [pfm_pkg::NUM_INST-1:0] filter_on_o,
    output logic [1:0] break_o
);
    import pfm_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    pfm_state_t state_q;
    pfm_state_t state_d;
    logic setup_ph;
    logic access_ph;
    logic sel_inst;
    logic [11:0] word_off;
    logic half_rd;
    logic word_hit;
    logic bus_err;

    assign setup_ph = psel_i && !penable_i;
    assign access_ph = psel_i && penable_i;
    assign sel_inst = paddr_i[7];
    assign word_off = {paddr_i[11:8], 1'b0, paddr_i[6:2], 2'b00};
    assign half_rd = (paddr_i[1:0] == 2'b10) && (word_off == OFF_REGULAR) && !pwrite_i;
    assign word_hit = (word_off >= OFF_INSERTED) && (word_off <= OFF_CONTROL);
    assign bus_err = !word_hit || ((paddr_i[1:0] != 2'b00) && !half_rd);

    // The slave never stretches a transfer: read data is captured at the end of setup.
    assign pready_o = 1'b1;
    assign prdata_o = state_q.prdata;
    assign pslverr_o = state_q.pslverr;
    assign break_o = state_q.brk;

    for (genvar g = 0; g < NUM_INST; g++) begin : g_out
        assign regular_done_flag_o[g] = state_q.inst[g].regular_done_flag;
        assign limit_event_flag_o[g] = |{state_q.inst[g].upper_limit_flags,
                                         state_q.inst[g].lower_limit_flags};
        assign filter_on_o[g] = state_q.inst[g].filter_on;
    end

    function automatic logic [31:0] read_word(pfm_inst_t s, logic [11:0] w, logic half);
        logic [31:0] r;
        r = 32'h00000000;
        unique case (w)
            OFF_INSERTED: r = (32'(s.inserted_result) << VAL_LSB) | (32'(s.inserted_source_tag) << TAG_BIT);
            OFF_REGULAR: begin
                if (half) begin
                    r = 32'(s.regular_result[VAL_W-1 -: 16]) << HALF_LSB;
                end else begin
                    r = (32'(s.regular_result) << VAL_LSB) | (32'(s.regular_delayed_tag) << DELAY_BIT)
                        | (32'(s.regular_source_tag) << TAG_BIT);
                end
            end
            OFF_HIGH_LIMIT: r = (32'(s.upper_limit_value) << VAL_LSB) | (32'(s.upper_break_route) << ROUTE_LSB);
            OFF_LOW_LIMIT: r = (32'(s.lower_limit_value) << VAL_LSB) | (32'(s.lower_break_route) << ROUTE_LSB);
            OFF_LIMIT_FLAGS: r = (32'(s.upper_limit_flags) << UPPER_FLAG_LSB)
                                 | (32'(s.lower_limit_flags) << LOWER_FLAG_LSB);
            OFF_PEAK_HIGH: r = (32'(s.peak_high_value) << VAL_LSB) | (32'(s.peak_high_source) << TAG_BIT);
            OFF_PEAK_LOW: r = (32'(s.peak_low_value) << VAL_LSB) | (32'(s.peak_low_source) << TAG_BIT);
            OFF_CONTROL: r = (32'(s.filter_on) << CTRL_ON_BIT) | (32'(s.fast_monitor_select) << CTRL_FAST_BIT);
            default: r = 32'h00000000;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state.

    always_comb begin
        logic wr;
        logic rd;
        logic above;
        logic below;
        logic [1:0] hev;
        logic [1:0] lev;
        logic pval;
        logic [VAL_W-1:0] pv;
        logic ps;
        logic [11:0] w;
        pfm_inst_t cur;
        wr = 1'b0;
        rd = 1'b0;
        above = 1'b0;
        below = 1'b0;
        hev = 2'b00;
        lev = 2'b00;
        pval = 1'b0;
        pv = '0;
        ps = 1'b0;
        w = word_off;
        cur = state_q.inst[0];
        state_d = state_q;
        for (int i = 0; i < NUM_INST; i++) begin
            cur = state_q.inst[i];
            wr = access_ph && pwrite_i && !bus_err && (sel_inst == 1'(i));
            rd = access_ph && !pwrite_i && !bus_err && (sel_inst == 1'(i));

            if (ins_done_i[i]) begin
                state_d.inst[i].inserted_result = ins_data_i[i];
                state_d.inst[i].inserted_source_tag = ins_chan_i[i];
            end

            // A completion in the same cycle as the read wins, so no result goes unseen.
            if (rd && (w == OFF_REGULAR)) begin
                state_d.inst[i].regular_done_flag = 1'b0;
            end
            if (reg_done_i[i]) begin
                state_d.inst[i].regular_result = reg_data_i[i];
                state_d.inst[i].regular_delayed_tag = reg_delayed_i[i];
                state_d.inst[i].regular_source_tag = reg_chan_i[i];
                state_d.inst[i].regular_done_flag = 1'b1;
            end

            if (wr) begin
                unique case (w)
                    OFF_HIGH_LIMIT: begin
                        state_d.inst[i].upper_limit_value = pwdata_i[VAL_LSB +: VAL_W];
                        state_d.inst[i].upper_break_route = pwdata_i[ROUTE_LSB +: 2];
                    end
                    OFF_LOW_LIMIT: begin
                        state_d.inst[i].lower_limit_value = pwdata_i[VAL_LSB +: VAL_W];
                        state_d.inst[i].lower_break_route = pwdata_i[ROUTE_LSB +: 2];
                    end
                    OFF_FLAG_CLEAR: begin
                        state_d.inst[i].upper_limit_flags = cur.upper_limit_flags
                                                           & ~pwdata_i[UPPER_FLAG_LSB +: 2];
                        state_d.inst[i].lower_limit_flags = cur.lower_limit_flags
                                                           & ~pwdata_i[LOWER_FLAG_LSB +: 2];
                    end
                    OFF_CONTROL: begin
                        state_d.inst[i].filter_on = pwdata_i[CTRL_ON_BIT];
                        state_d.inst[i].fast_monitor_select = pwdata_i[CTRL_FAST_BIT];
                    end
                    default: begin
                    end
                endcase
            end

            // Fast mode drops the low byte of both data and limits.
            if (cur.fast_monitor_select) begin
                above = $signed(mon_data_i[i][VAL_W-1:FAST_LSB]) > $signed(cur.upper_limit_value[VAL_W-1:FAST_LSB]);
                below = $signed(mon_data_i[i][VAL_W-1:FAST_LSB]) < $signed(cur.lower_limit_value[VAL_W-1:FAST_LSB]);
            end else begin
                above = $signed(mon_data_i[i]) > $signed(cur.upper_limit_value);
                below = $signed(mon_data_i[i]) < $signed(cur.lower_limit_value);
            end
            hev[i] = cur.filter_on && mon_valid_i[i] && above;
            lev[i] = cur.filter_on && mon_valid_i[i] && below;
            if (hev[i]) begin
                state_d.inst[i].upper_limit_flags[mon_chan_i[i]] = 1'b1;
            end
            if (lev[i]) begin
                state_d.inst[i].lower_limit_flags[mon_chan_i[i]] = 1'b1;
            end
            if (!cur.filter_on || !state_d.inst[i].filter_on) begin
                state_d.inst[i].upper_limit_flags = 2'b00;
                state_d.inst[i].lower_limit_flags = 2'b00;
            end

            if (rd && (w == OFF_PEAK_HIGH)) begin
                state_d.inst[i].peak_high_value = PEAK_HIGH_RST[VAL_LSB +: VAL_W];
                state_d.inst[i].peak_high_source = PEAK_HIGH_RST[TAG_BIT];
            end
            if (rd && (w == OFF_PEAK_LOW)) begin
                state_d.inst[i].peak_low_value = PEAK_LOW_RST[VAL_LSB +: VAL_W];
                state_d.inst[i].peak_low_source = PEAK_LOW_RST[TAG_BIT];
            end
            // Regular results take precedence when both groups finish together.
            pval = reg_done_i[i] || ins_done_i[i];
            pv = reg_done_i[i] ? reg_data_i[i] : ins_data_i[i];
            ps = reg_done_i[i] ? reg_chan_i[i] : ins_chan_i[i];
            if (pval && ($signed(pv) > $signed(state_d.inst[i].peak_high_value))) begin
                state_d.inst[i].peak_high_value = pv;
                state_d.inst[i].peak_high_source = ps;
            end
            if (pval && ($signed(pv) < $signed(state_d.inst[i].peak_low_value))) begin
                state_d.inst[i].peak_low_value = pv;
                state_d.inst[i].peak_low_source = ps;
            end
        end

        state_d.brk = 2'b00;
        for (int i = 0; i < NUM_INST; i++) begin
            state_d.brk = state_d.brk | ({2{hev[i]}} & state_q.inst[i].upper_break_route)
                                      | ({2{lev[i]}} & state_q.inst[i].lower_break_route);
        end

        // Capture from the updated state so a result landing at this edge is what gets returned.
        if (setup_ph) begin
            state_d.pslverr = bus_err;
            state_d.prdata = (bus_err || pwrite_i) ? 32'h00000000
                           : read_word(state_d.inst[sel_inst], word_off, half_rd);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= '0;
            for (int i = 0; i < NUM_INST; i++) begin
                state_q.inst[i].peak_high_value <= PEAK_HIGH_RST[VAL_LSB +: VAL_W];
                state_q.inst[i].peak_low_value <= PEAK_LOW_RST[VAL_LSB +: VAL_W];
            end
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    logic rd_done0;
    assign rd_done0 = access_ph && !pwrite_i && !paddr_i[7];

    property p_ins_tag;
        ins_done_i[0] |=> state_q.inst[0].inserted_source_tag == $past(ins_chan_i[0]);
    endproperty
    a_ins_tag: assert property (p_ins_tag) else $error("inserted tag not updated");

    property p_reg_store;
        reg_done_i[0] |=> (state_q.inst[0].regular_result == $past(reg_data_i[0])) && regular_done_flag_o[0];
    endproperty
    a_reg_store: assert property (p_reg_store) else $error("regular result not stored");

    property p_read_clear;
        rd_done0 && (paddr_i == OFF_REGULAR) && !reg_done_i[0] |=> !regular_done_flag_o[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear done flag");

    property p_half_read;
        setup_ph && !pwrite_i && (paddr_i == OFF_REGULAR + 12'h002)
            |=> !pslverr_o && (prdata_o[15:0] == 16'h0000);
    endproperty
    a_half_read: assert property (p_half_read) else $error("half read refused or wrong");

    property p_reg_tags;
        reg_done_i[0] |=> state_q.inst[0].regular_delayed_tag == $past(reg_delayed_i[0])
            && state_q.inst[0].regular_source_tag == $past(reg_chan_i[0]);
    endproperty
    a_reg_tags: assert property (p_reg_tags) else $error("regular tags wrong");

    property p_break_route;
        mon_valid_i[0] && !mon_valid_i[1] && state_q.inst[0].filter_on && !state_q.inst[0].fast_monitor_select
            && ($signed(mon_data_i[0]) > $signed(state_q.inst[0].upper_limit_value))
            && (state_q.inst[0].upper_break_route == 2'b01) && (state_q.inst[0].lower_break_route == 2'b00)
            |=> (break_o == 2'b01) ##1 (break_o == 2'b00 || $past(mon_valid_i, 1) != 2'b00);
    endproperty
    a_break_route: assert property (p_break_route) else $error("break routing wrong");

    property p_off_clear;
        !state_q.inst[0].filter_on |=> (state_q.inst[0].upper_limit_flags == 2'b00)
            && (state_q.inst[0].lower_limit_flags == 2'b00);
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("flags alive while off");

    property p_flag_clear;
        access_ph && pwrite_i && (paddr_i == OFF_FLAG_CLEAR) && (pwdata_i[9:8] == 2'b11) && !mon_valid_i[0]
            |=> state_q.inst[0].upper_limit_flags == 2'b00;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("high flags not cleared");

    property p_peak_reset;
        rd_done0 && (paddr_i == OFF_PEAK_HIGH) && !reg_done_i[0] && !ins_done_i[0]
            |=> {state_q.inst[0].peak_high_value, state_q.inst[0].peak_high_source} == {24'h800000, 1'b0};
    endproperty
    a_peak_reset: assert property (p_peak_reset) else $error("peak high not reset by read");

    property p_event_flag;
        $fell(limit_event_flag_o[0]) |-> (state_q.inst[0].upper_limit_flags == 2'b00)
            && (state_q.inst[0].lower_limit_flags == 2'b00);
    endproperty
    a_event_flag: assert property (p_event_flag) else $error("event flag fell with flags set");

    c_reg_read: cover property (reg_done_i[0] ##[1:20] rd_done0 && (paddr_i == OFF_REGULAR));
    c_high_flag: cover property (state_q.inst[1].upper_limit_flags == 2'b11);
    c_peak_read: cover property (rd_done0 && (paddr_i == OFF_PEAK_LOW));
    c_break_both: cover property (break_o == 2'b11);

endmodule // pfm_result_monitor

// [dv/pfm_result_monitor_bench.sv]
`timescale 1ns/1ps
module pfm_result_monitor_bench;
    import pfm_pkg::*;
    typedef struct packed {logic [11:0] addr; logic [31:0] exp; logic err;} pfm_row_t;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready, pslverr;
    logic [NUM_INST-1:0] reg_done = '0, reg_chan = '0, reg_dly = '0, ins_done = '0, ins_chan = '0;
    logic [NUM_INST-1:0] mon_valid = '0, mon_chan = '0;
    logic [NUM_INST-1:0][VAL_W-1:0] reg_data = '0, ins_data = '0, mon_data = '0;
    logic [NUM_INST-1:0] done_flag, event_flag, filt_on;
    logic [1:0] brk, brk_seen;
    logic [31:0] rd;
    logic er;
    int num_errors = 0;
    int n_checks = 0;
    int cycles = 0;
    // Unmapped, unaligned and read-only places are mixed in with the reset values.
    pfm_row_t rows [14] = '{'{12'h11c, 32'h0, 1'b0}, '{12'h120, 32'h0, 1'b0}, '{12'h124, 32'h0, 1'b0},
        '{12'h128, 32'h0, 1'b0}, '{12'h12c, 32'h0, 1'b0}, '{12'h130, 32'h80000000, 1'b0},
        '{12'h134, 32'h7fffff00, 1'b0}, '{12'h19c, 32'h0, 1'b0}, '{12'h1b0, 32'h80000000, 1'b0},
        '{12'h1b4, 32'h7fffff00, 1'b0}, '{12'h138, 32'h0, 1'b0}, '{12'h100, 32'h0, 1'b1},
        '{12'h11d, 32'h0, 1'b1}, '{12'h13c, 32'h0, 1'b1}};

    pfm_result_monitor dut (
        .core_clk_i(core_clk),
        .reset_i(reset),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .reg_done_i(reg_done),
        .reg_data_i(reg_data),
        .reg_chan_i(reg_chan),
        .reg_delayed_i(reg_dly),
        .ins_done_i(ins_done),
        .ins_data_i(ins_data),
        .ins_chan_i(ins_chan),
        .mon_valid_i(mon_valid),
        .mon_data_i(mon_data),
        .mon_chan_i(mon_chan),
        .regular_done_flag_o(done_flag),
        .limit_event_flag_o(event_flag),
        .filter_on_o(filt_on),
        .break_o(brk)
    );

    always #5 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The whole sequence needs well under a thousand cycles.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            $display("wrong value at %0t: run hung", $time);
            summarize();
        end
    end

    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    // Entered just after a rising edge; leaves one idle cycle so no signal is set twice in a step.
    // Waits for ready with no count of its own; only the bench timeout ends a stuck transfer.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk_reg(rd, exp, what);
        chk_pin({1'b0, pready}, 2'b01, "ready");
    endtask

    // Kind 0 regular, 1 inserted, 2 monitor sample; break_o is caught in the cycle after the sample.
    task automatic conv(input int kind, input int i, input logic [23:0] d, input logic ch, input logic dl);
        case (kind)
            0: begin
                reg_done[i] <= 1'b1; reg_data[i] <= d; reg_chan[i] <= ch; reg_dly[i] <= dl;
            end
            1: begin
                ins_done[i] <= 1'b1; ins_data[i] <= d; ins_chan[i] <= ch;
            end
            default: begin
                mon_valid[i] <= 1'b1; mon_data[i] <= d; mon_chan[i] <= ch;
            end
        endcase
        @(posedge core_clk);
        reg_done <= '0;
        ins_done <= '0;
        mon_valid <= '0;
        @(posedge core_clk);
        brk_seen = brk;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        for (int k = 0; k < 14; k++) begin
            rdchk(rows[k].addr, rows[k].exp, "reset value");
            chk_pin({1'b0, er}, {1'b0, rows[k].err}, "slave error");
        end
        apb(1'b1, OFF_REGULAR, 32'hffffffff);
        rdchk(OFF_REGULAR, 32'h0, "read-only write");
        $display("test reset values done");

        conv(0, 0, 24'h123456, 1'b1, 1'b1);
        chk_pin(done_flag, 2'b01, "done flag");
        rdchk(OFF_REGULAR, 32'h12345611, "regular");
        chk_pin(done_flag, 2'b00, "done after read");
        conv(0, 0, 24'habcdef, 1'b0, 1'b0);
        rdchk(OFF_REGULAR + 12'h2, 32'habcd0000, "half read");
        chk_pin(done_flag, 2'b00, "done after half");
        conv(1, 1, 24'h00aa55, 1'b1, 1'b0);
        rdchk(OFF_INSERTED + INST_STRIDE, 32'h00aa5501, "inserted");
        rdchk(OFF_REGULAR + INST_STRIDE, 32'h0, "other instance");
        $display("test conversions done");

        rdchk(OFF_PEAK_HIGH, 32'h12345601, "peak high");
        rdchk(OFF_PEAK_HIGH, PEAK_HIGH_RST, "peak high reread");
        rdchk(OFF_PEAK_LOW, 32'habcdef00, "peak low");
        rdchk(OFF_PEAK_LOW, PEAK_LOW_RST, "peak low reread");
        rdchk(OFF_PEAK_HIGH + INST_STRIDE, 32'h00aa5501, "peak high inst1");
        $display("test peaks done");

        apb(1'b1, OFF_CONTROL, 32'h1);
        chk_pin(filt_on, 2'b01, "filter on");
        apb(1'b1, OFF_LOW_LIMIT, 32'hffff0002);
        rdchk(OFF_LOW_LIMIT, 32'hffff0002, "low limit");
        for (int r = 0; r < 4; r++) begin
            apb(1'b1, OFF_HIGH_LIMIT, 32'h00010000 | 32'(r));
            conv(2, 0, 24'h000200, 1'b0, 1'b0);
            chk_pin(brk_seen, r[1:0], "high route");
        end
        rdchk(OFF_HIGH_LIMIT, 32'h00010003, "high limit");
        rdchk(OFF_LIMIT_FLAGS, 32'h100, "flags high");
        chk_pin(event_flag, 2'b01, "event");
        // A sample equal to the high limit is not above it, so no flag and no break.
        conv(2, 0, 24'h000100, 1'b1, 1'b0);
        chk_pin(brk_seen, 2'b00, "in range");
        conv(2, 0, 24'hfffe00, 1'b1, 1'b0);
        chk_pin(brk_seen, 2'b10, "low route 10");
        apb(1'b1, OFF_LOW_LIMIT, 32'hffff0003);
        conv(2, 0, 24'hfffe00, 1'b0, 1'b0);
        chk_pin(brk_seen, 2'b11, "low route 11");
        rdchk(OFF_LIMIT_FLAGS, 32'h103, "flags low");
        apb(1'b1, OFF_FLAG_CLEAR, 32'h0);
        rdchk(OFF_LIMIT_FLAGS, 32'h103, "clear zeros");
        apb(1'b1, OFF_FLAG_CLEAR, 32'h101);
        rdchk(OFF_LIMIT_FLAGS, 32'h002, "clear ch0");
        chk_pin(event_flag, 2'b01, "event kept");
        apb(1'b1, OFF_FLAG_CLEAR, 32'h002);
        rdchk(OFF_LIMIT_FLAGS, 32'h0, "clear ch1");
        chk_pin(event_flag, 2'b00, "event cleared");
        $display("test limits done");

        apb(1'b1, OFF_CONTROL, 32'h3);
        apb(1'b1, OFF_HIGH_LIMIT, 32'h00018001);
        conv(2, 0, 24'h0001ff, 1'b0, 1'b0);
        chk_pin(brk_seen, 2'b00, "fast equal");
        conv(2, 0, 24'h000200, 1'b1, 1'b0);
        chk_pin(brk_seen, 2'b01, "fast above");
        rdchk(OFF_LIMIT_FLAGS, 32'h200, "fast flag");
        apb(1'b1, OFF_CONTROL, 32'h0);
        rdchk(OFF_LIMIT_FLAGS, 32'h0, "flags off");
        chk_pin(filt_on, 2'b00, "filter off");
        conv(2, 0, 24'h000300, 1'b0, 1'b0);
        rdchk(OFF_LIMIT_FLAGS, 32'h0, "flags stay off");
        $display("test fast and off done");
        summarize();
    end
endmodule // pfm_result_monitor_bench
